// [bench/nad_pins_model.sv]
`timescale 1ns/1ns
module nad_pins_model (
    input wire logic mclk,
    input wire logic [3:0] lvl,
    output logic [3:0] in_port
);
    // Pins move on the clock, never racing the synchroniser
    always @(posedge mclk)
    begin
        in_port <= lvl;
    end
endmodule : nad_pins_model

// [bench/nad_top_chk.sv]
`timescale 1ns/1ns
module nad_top_chk #(
    parameter int RAM_REGS = 4,
    parameter int RAM_DIGITS = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] in_port,
    input wire logic [7:0] parallel_out,
    input wire logic [3:0] general_out,
    input wire logic [3:0] data_out,
    input wire logic [9:0] pc_out
);
    logic take;
    logic rd;
    logic wr;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd = take & ~wb_we_i;
    assign wr = take & wb_we_i;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
    ack_latency_a:
        assert property (take |=> wb_ack_o) else $error("ack missing one cycle after request");
    ack_cause_a:
        assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
    pc_step_a:
        assert property (wr && wb_sel_i[0] && wb_adr_i == nad_pkg::OFS_INSTR |=>
            pc_out == $past(pc_out) + 10'h001) else $error("pc did not step by one");
    pc_hold_a:
        assert property (!wr |=> $stable(pc_out)) else $error("pc moved without a write");
    ptr_width_a:
        assert property (rd && wb_adr_i == nad_pkg::OFS_POINTER |=> wb_dat_o[31:6] == 26'h000_0000)
            else $error("pointer wider than six bits");
    pc_read_a:
        assert property (rd && wb_adr_i == nad_pkg::OFS_PC |=> wb_dat_o == {22'h00_0000, $past(pc_out)})
            else $error("pc read differs from pc pins");
    par_read_a:
        assert property (rd && wb_adr_i == nad_pkg::OFS_PARALLEL_OUT |=>
            wb_dat_o == {24'h00_0000, $past(parallel_out)}) else $error("parallel read differs");
    dout_read_a:
        assert property (rd && wb_adr_i == nad_pkg::OFS_DATA_OUT |=> wb_dat_o[3:0] == $past(data_out))
            else $error("data out read differs");
    dat_hold_a:
        assert property (!rd |=> $stable(wb_dat_o)) else $error("read data changed without a read");
endmodule : nad_top_chk

bind nad_top nad_top_chk #(.RAM_REGS(RAM_REGS), .RAM_DIGITS(RAM_DIGITS)) u_chk (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_port(in_port),
    .parallel_out(parallel_out), .general_out(general_out), .data_out(data_out), .pc_out(pc_out));

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic mclk;
    logic rst_b;
    logic [3:0] pin_lvl;
    logic [3:0] in_port;
    logic [31:0] dat_o;
    logic ack;
    logic [7:0] par;
    logic [3:0] gen;
    logic [3:0] dout;
    logic [9:0] pc;
    nad_pkg::nad_wb_req_t req;
    int mismatches;
    int num_checks;

    nad_top u_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .in_port(in_port), .parallel_out(par), .general_out(gen), .data_out(dout), .pc_out(pc));
    nad_pins_model u_pins (.mclk(mclk), .lvl(pin_lvl), .in_port(in_port));

    always #4 mclk = ~mclk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            mismatches++;
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        input logic [3:0] sel, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge mclk);
        req <= {1'b1, 1'b1, we, sel, adr, dat};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        req <= '0;
        chk({31'h0000_0000, ack}, 32'h0000_0001);
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, a, d, 4'hf, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hf, d);
    endtask : rd

    task automatic exec(input logic [7:0] op);
        wr(nad_pkg::OFS_INSTR, {24'h00_0000, op});
    endtask : exec

    // Returns skip, carry, acc
    function automatic logic [5:0] ref_alu(logic [7:0] op, logic [3:0] a, logic c, logic [3:0] m);
        logic [4:0] s;
        logic nc;
        case (op)
            8'h30: s = {1'b0, a} + m + c;
            8'h10: s = {1'b0, ~a} + m + c;
            8'h31: s = {1'b0, a} + m;
            8'h4a: s = {1'b0, a} + 5'h0a;
            8'h02: s = {1'b0, a ^ m};
            8'h40: s = {1'b0, ~a};
            8'h00: s = 5'h00;
            default: s = (op[7:4] == 4'h5) ? {1'b0, a} + op[3:0] : {1'b0, a};
        endcase
        nc = (op == 8'h30 || op == 8'h10) ? s[4] : (op == 8'h22) ? 1'b1 : (op == 8'h32) ? 1'b0 : c;
        return {(op == 8'h30 || op == 8'h10 || op[7:4] == 4'h5) & s[4], nc, s[3:0]};
    endfunction : ref_alu

    task automatic t_reset;
        logic [31:0] v;
        rd(nad_pkg::OFS_STATUS, v);
        chk(v, 32'h0000_0000);
        rd(nad_pkg::OFS_PC, v);
        chk(v, 32'h0000_0000);
        rd(8'h30, v);
        chk(v, 32'h0000_0000);
        rd(nad_pkg::OFS_RAM_WINDOW, v);
        chk(v, 32'h0000_0000);
        chk({16'h0000, par, gen, dout}, 32'h0000_0000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_alu;
        logic [7:0] ops [13] = '{8'h30, 8'h31, 8'h4a, 8'h50, 8'h51, 8'h5f, 8'h10, 8'h00, 8'h40, 8'h44,
            8'h32, 8'h22, 8'h02};
        logic [8:0] vec [2] = '{{4'hf, 1'b1, 4'h1}, {4'h3, 1'b0, 4'h5}};
        logic [5:0] e;
        logic [31:0] v;
        wr(nad_pkg::OFS_POINTER, 32'h0000_001a);
        foreach (ops[i])
        begin
            foreach (vec[j])
            begin
                wr(nad_pkg::OFS_RAM_WINDOW + 8'h68, {28'h000_0000, vec[j][3:0]});
                exec(8'h00);
                exec({4'h5, vec[j][8:5]});
                exec(vec[j][4] ? 8'h22 : 8'h32);
                exec(ops[i]);
                e = ref_alu(ops[i], vec[j][8:5], vec[j][4], vec[j][3:0]);
                rd(nad_pkg::OFS_STATUS, v);
                chk(v[5:0], e);
                exec(8'h40);
                rd(nad_pkg::OFS_STATUS, v);
                chk(v[5:0], e[5] ? {1'b0, e[4:0]} : {1'b0, e[4], ~e[3:0]});
            end
        end
        $display("alu test done");
    endtask : t_alu

    task automatic t_pointer;
        logic [5:0] ptr [3] = '{6'h25, 6'h05, 6'h29};
        logic [3:0] nib [3] = '{4'h7, 4'h2, 4'hc};
        logic [31:0] v;
        foreach (ptr[i])
            wr(nad_pkg::OFS_RAM_WINDOW + {ptr[i], 2'b00}, {28'h000_0000, nib[i]});
        foreach (ptr[i])
        begin
            wr(nad_pkg::OFS_POINTER, {26'h000_0000, ptr[i]});
            exec(8'h00);
            exec(8'h31);
            rd(nad_pkg::OFS_STATUS, v);
            chk(v[3:0], nib[i]);
        end
        wr(nad_pkg::OFS_POINTER, 32'hffff_ffff);
        rd(nad_pkg::OFS_POINTER, v);
        chk(v, 32'h0000_003f);
        $display("pointer test done");
    endtask : t_pointer

    task automatic t_regs;
        logic [7:0] stk [3] = '{nad_pkg::OFS_STACK_TOP, nad_pkg::OFS_STACK_MID, nad_pkg::OFS_STACK_BOT};
        logic [31:0] p;
        logic [31:0] v;
        rd(nad_pkg::OFS_PC, p);
        exec(8'h44);
        rd(nad_pkg::OFS_PC, v);
        chk(v, p + 32'h0000_0001);
        wr(nad_pkg::OFS_PC, 32'h0000_03ff);
        exec(8'h44);
        chk({22'h00_0000, pc}, 32'h0000_0000);
        foreach (stk[i])
        begin
            wr(stk[i], 32'hffff_ffff);
            rd(stk[i], v);
            chk(v, 32'h0000_03ff);
        end
        wr(nad_pkg::OFS_PARALLEL_OUT, 32'hffff_ffa5);
        chk({24'h00_0000, par}, 32'h0000_00a5);
        wr(nad_pkg::OFS_GENERAL_OUT, 32'h0000_0006);
        chk({28'h000_0000, gen}, 32'h0000_0006);
        wr(nad_pkg::OFS_DATA_OUT, 32'h0000_0009);
        wb_xfer(1'b1, nad_pkg::OFS_DATA_OUT, 32'h0000_0003, 4'h0, v);
        chk({28'h000_0000, dout}, 32'h0000_0009);
        $display("register test done");
    endtask : t_regs

    task automatic t_latch;
        logic [31:0] v;
        pin_lvl <= 4'h9;
        repeat (6) @(posedge mclk);
        rd(nad_pkg::OFS_STATUS, v);
        chk(v[7:6], 2'b11);
        pin_lvl <= 4'h0;
        repeat (6) @(posedge mclk);
        wr(nad_pkg::OFS_STATUS, 32'h0000_00c0);
        rd(nad_pkg::OFS_STATUS, v);
        chk(v[7:6], 2'b00);
        rd(nad_pkg::OFS_SHIFT_COUNT, v);
        chk(v, 32'h0000_0001);
        wr(nad_pkg::OFS_SHIFT_COUNT, 32'h0000_0005);
        rd(nad_pkg::OFS_SHIFT_COUNT, v);
        chk(v, 32'h0000_0005);
        wr(nad_pkg::OFS_CONTROL, 32'h0000_0001);
        pin_lvl <= 4'h1;
        repeat (8) @(posedge mclk);
        rd(nad_pkg::OFS_SHIFT_COUNT, v);
        chk(v, 32'h0000_000f);
        rd(nad_pkg::OFS_CONTROL, v);
        chk(v, 32'h0000_0001);
        wr(nad_pkg::OFS_CONTROL, 32'h0000_0000);
        $display("latch test done");
    endtask : t_latch

    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        pin_lvl = 4'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_alu;
        t_pointer;
        t_regs;
        t_latch;
        stop_test;
    end

    // Whole run needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test;
    end
endmodule : testbench

// [hdl/nad_alu.sv]
`timescale 1ns/1ns
module nad_alu (
    input wire logic [7:0] opcode,
    input wire logic [3:0] acc,
    input wire logic carry,
    input wire logic [3:0] mem_nibble,
    output nad_pkg::nad_alu_res_t res
);

    function automatic logic [4:0] add3(input logic [3:0] x, input logic [3:0] y, input logic cin);
        add3 = {1'b0, x} + {1'b0, y} + {4'h0, cin};
    endfunction : add3

    logic [4:0] sum;

    always_comb
    begin
        sum = 5'h00;
        res = '{acc: acc, carry: carry, skip: 1'b0, acc_we: 1'b0, carry_we: 1'b0};
        if (opcode[7:4] == nad_pkg::OPC_ADD_IMMEDIATE_HI)
        begin
            // Zero immediate is not a valid form; treated as a plain no-op add
            sum = add3(acc, opcode[3:0], 1'b0);
            res.acc = sum[3:0];
            res.acc_we = 1'b1;
            res.skip = sum[4] && (opcode[3:0] != 4'h0);
        end
        else
        begin
            case (opcode)
                nad_pkg::OPC_ADD_WITH_CARRY_SKIP:
                begin
                    sum = add3(acc, mem_nibble, carry);
                    res = '{acc: sum[3:0], carry: sum[4], skip: sum[4], acc_we: 1'b1, carry_we: 1'b1};
                end
                nad_pkg::OPC_COMPLEMENT_ADD_CARRY_SKIP:
                begin
                    sum = add3(~acc, mem_nibble, carry);
                    res = '{acc: sum[3:0], carry: sum[4], skip: sum[4], acc_we: 1'b1, carry_we: 1'b1};
                end
                nad_pkg::OPC_ADD_RAM:
                begin
                    sum = add3(acc, mem_nibble, 1'b0);
                    res.acc = sum[3:0];
                    res.acc_we = 1'b1;
                end
                nad_pkg::OPC_ADD_TEN_DECIMAL:
                begin
                    sum = add3(acc, nad_pkg::TEN_VALUE, 1'b0);
                    res.acc = sum[3:0];
                    res.acc_we = 1'b1;
                end
                nad_pkg::OPC_ONES_COMPLEMENT:
                begin
                    res.acc = ~acc;
                    res.acc_we = 1'b1;
                end
                nad_pkg::OPC_EXCLUSIVE_OR:
                begin
                    res.acc = acc ^ mem_nibble;
                    res.acc_we = 1'b1;
                end
                nad_pkg::OPC_CLEAR_ACCUMULATOR:
                begin
                    res.acc = nad_pkg::ACC_RST;
                    res.acc_we = 1'b1;
                end
                nad_pkg::OPC_CLEAR_CARRY_FLAG:
                begin
                    res.carry = 1'b0;
                    res.carry_we = 1'b1;
                end
                nad_pkg::OPC_SET_CARRY:
                begin
                    res.carry = 1'b1;
                    res.carry_we = 1'b1;
                end
                nad_pkg::OPC_NO_OPERATION:
                begin
                    res.acc_we = 1'b0;
                end
                default:
                begin
                    res.acc_we = 1'b0;
                end
            endcase
        end
    end

endmodule : nad_alu

// [hdl/nad_pkg.sv]
package nad_pkg;

    localparam int ACC_W = 4;
    localparam int PTR_W = 6;
    localparam int REG_SEL_W = 2;
    localparam int DIG_SEL_W = 4;
    localparam int PC_W = 10;
    localparam int OPC_W = 8;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;

    localparam logic [7:0] OPC_ADD_WITH_CARRY_SKIP = 8'h30;
    localparam logic [7:0] OPC_ADD_RAM = 8'h31;
    localparam logic [7:0] OPC_ADD_TEN_DECIMAL = 8'h4a;
    localparam logic [3:0] OPC_ADD_IMMEDIATE_HI = 4'h5;
    localparam logic [7:0] OPC_COMPLEMENT_ADD_CARRY_SKIP = 8'h10;
    localparam logic [7:0] OPC_CLEAR_ACCUMULATOR = 8'h00;
    localparam logic [7:0] OPC_ONES_COMPLEMENT = 8'h40;
    localparam logic [7:0] OPC_NO_OPERATION = 8'h44;
    localparam logic [7:0] OPC_CLEAR_CARRY_FLAG = 8'h32;
    localparam logic [7:0] OPC_SET_CARRY = 8'h22;
    localparam logic [7:0] OPC_EXCLUSIVE_OR = 8'h02;
    localparam logic [3:0] TEN_VALUE = 4'ha;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_POINTER = 8'h0c;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_STACK_TOP = 8'h14;
    localparam logic [7:0] OFS_STACK_MID = 8'h18;
    localparam logic [7:0] OFS_STACK_BOT = 8'h1c;
    localparam logic [7:0] OFS_SHIFT_COUNT = 8'h20;
    localparam logic [7:0] OFS_PARALLEL_OUT = 8'h24;
    localparam logic [7:0] OFS_GENERAL_OUT = 8'h28;
    localparam logic [7:0] OFS_DATA_OUT = 8'h2c;
    localparam logic [7:0] OFS_RAM_WINDOW = 8'h40;

    localparam int STAT_ACC_LSB = 0;
    localparam int STAT_CARRY_BIT = 4;
    localparam int STAT_SKIP_BIT = 5;
    localparam int STAT_LATCH_LSB = 6;
    localparam int CTRL_SHIFT_MODE_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;

    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } nad_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } nad_wb_rsp_t;

    typedef struct packed {
        logic [3:0] acc;
        logic carry;
        logic skip;
        logic acc_we;
        logic carry_we;
    } nad_alu_res_t;

endpackage : nad_pkg

// [hdl/nad_ram.sv]
`timescale 1ns/1ns
module nad_ram #(
    parameter int REGS = 4,
    parameter int DIGITS = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] rd_reg_sel,
    input wire logic [3:0] rd_dig_sel,
    output logic [3:0] rd_nibble,
    input wire logic wr_en,
    input wire logic [1:0] wr_reg_sel,
    input wire logic [3:0] wr_dig_sel,
    input wire logic [3:0] wr_nibble
);

    logic [3:0] mem_ff [REGS*DIGITS];

    function automatic int idx(input logic [1:0] r, input logic [3:0] d);
        idx = int'(r) * DIGITS + int'(d);
    endfunction : idx

    // Register select picks the row, digit select the nibble
    assign rd_nibble = mem_ff[idx(rd_reg_sel, rd_dig_sel)];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < REGS*DIGITS; i++)
                mem_ff[i] <= 4'h0;
        end
        else if (wr_en)
        begin
            mem_ff[idx(wr_reg_sel, wr_dig_sel)] <= wr_nibble;
        end
    end

endmodule : nad_ram

// [hdl/nad_top.sv]
`timescale 1ns/1ns
// Summary of operation
// - 0x30 adds A, carry and RAM nibble; carry out to C; skip on carry.
// - 0x5y adds immediate y to A, carry untouched, skip on carry; y=0 invalid.
// - 0x10 adds inverted A, RAM nibble and carry; carry to C; skip on carry.
// - 0x40 inverts A; carry unchanged; never skips.
// - 0x02 XORs A with RAM nibble; carry unchanged; no skip.
// - A 6-bit RAM pointer selects the memory operand.
// - Pointer upper 2 bits select one of four RAM registers.
// - Pointer lower 4 bits select one of sixteen digits.
// - Memory operand is the 4-bit word chosen by the full pointer.
// - A 10-bit program counter addresses ROM 0 to 1023.
// - Three 10-bit return registers form a three-level stack.
// - A 4-bit register works as shift register or binary counter.
// - A 4-bit data output port is driven from a register.
// - Two 1-bit latches follow input lines 3 and 0.
// - Immediate field is 4 bits, values 0 to 15.
// - Register select field is 2 bits, values 0 to 3.
// - ROM address field is 10 bits, values 0 to 1023.
// - Digit select field is 4 bits, values 0 to 15.
module nad_top #(
    parameter int RAM_REGS = 4,
    parameter int RAM_DIGITS = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] in_port,
    output logic [7:0] parallel_out,
    output logic [3:0] general_out,
    output logic [3:0] data_out,
    output logic [9:0] pc_out
);

    nad_pkg::nad_wb_req_t req;
    nad_pkg::nad_alu_res_t alu_res;

    logic [3:0] acc_ff;
    logic carry_ff;
    logic skip_ff;
    logic [5:0] ptr_ff;
    logic [9:0] pc_ff;
    logic [9:0] stack_top_ff;
    logic [9:0] stack_mid_ff;
    logic [9:0] stack_bot_ff;
    logic [3:0] shift_count_ff;
    logic shift_mode_ff;
    logic [7:0] parallel_ff;
    logic [3:0] general_ff;
    logic [3:0] data_ff;
    logic [3:0] in_meta_ff;
    logic [3:0] in_sync_ff;
    logic [1:0] latch_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [3:0] mem_nibble;
    logic [3:0] ram_wr_nibble;
    logic [31:0] nxt_rdata;
    logic bus_go;
    logic wr_go;
    logic exec_go;
    logic do_exec;
    logic ram_wr_go;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        for (int b = 0; b < 4; b++)
            merge[b*8 +: 8] = sel[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    endfunction : merge

    // Narrow registers take the byte merge of their low ten bits
    function automatic logic [9:0] merge10(input logic [9:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] m;
        m = merge({22'h00_0000, old}, wd, sel);
        merge10 = m[9:0];
    endfunction : merge10

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction : hit

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    // Single answer per request; ack drops the cycle after it rose
    assign bus_go = req.cyc && req.stb && !ack_ff;
    assign wr_go = bus_go && req.we;
    assign exec_go = wr_go && hit(req.adr, nad_pkg::OFS_INSTR) && req.sel[0];
    assign do_exec = exec_go && !skip_ff;
    // Nine-bit compare: window end lies past the 8-bit reach, so the top RAM row is not writable
    assign ram_wr_go = wr_go && (req.adr >= nad_pkg::OFS_RAM_WINDOW)
        && ({1'b0, req.adr} < 9'(nad_pkg::OFS_RAM_WINDOW) + 9'(4 * RAM_REGS * RAM_DIGITS)) && req.sel[0];
    assign ram_wr_nibble = req.dat[3:0];

    // Operand comes from the full pointer: register field high, digit field low
    nad_ram #(
        .REGS(RAM_REGS),
        .DIGITS(RAM_DIGITS)
    ) u_ram (
        .mclk(mclk),
        .rst_b(rst_b),
        .rd_reg_sel(ptr_ff[5:4]),
        .rd_dig_sel(ptr_ff[3:0]),
        .rd_nibble(mem_nibble),
        .wr_en(ram_wr_go),
        .wr_reg_sel(req.adr[7:6] - 2'h1),
        .wr_dig_sel(req.adr[5:2]),
        .wr_nibble(ram_wr_nibble)
    );

    nad_alu u_alu (
        .opcode(req.dat[7:0]),
        .acc(acc_ff),
        .carry(carry_ff),
        .mem_nibble(mem_nibble),
        .res(alu_res)
    );

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            acc_ff <= nad_pkg::ACC_RST;
        else if (do_exec && alu_res.acc_we)
            acc_ff <= alu_res.acc;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            carry_ff <= 1'b0;
        else if (do_exec && alu_res.carry_we)
            carry_ff <= alu_res.carry;
    end

    // Skipped instruction clears the pending skip and leaves A and C unchanged
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            skip_ff <= 1'b0;
        else if (exec_go)
            skip_ff <= do_exec && alu_res.skip;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ptr_ff <= 6'h00;
        else if (wr_go && hit(req.adr, nad_pkg::OFS_POINTER) && req.sel[0])
            ptr_ff <= req.dat[5:0];
    end

    // Each fetched instruction word advances the counter, skipped or not
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pc_ff <= 10'h000;
        else if (exec_go)
            pc_ff <= pc_ff + 10'h001;
        else if (wr_go && hit(req.adr, nad_pkg::OFS_PC))
            pc_ff <= merge10(pc_ff, req.dat, req.sel);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stack_top_ff <= 10'h000;
            stack_mid_ff <= 10'h000;
            stack_bot_ff <= 10'h000;
        end
        else if (wr_go)
        begin
            if (hit(req.adr, nad_pkg::OFS_STACK_TOP))
                stack_top_ff <= merge10(stack_top_ff, req.dat, req.sel);
            if (hit(req.adr, nad_pkg::OFS_STACK_MID))
                stack_mid_ff <= merge10(stack_mid_ff, req.dat, req.sel);
            if (hit(req.adr, nad_pkg::OFS_STACK_BOT))
                stack_bot_ff <= merge10(stack_bot_ff, req.dat, req.sel);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            shift_mode_ff <= 1'b0;
        else if (wr_go && hit(req.adr, nad_pkg::OFS_CONTROL) && req.sel[0])
            shift_mode_ff <= req.dat[nad_pkg::CTRL_SHIFT_MODE_BIT];
    end

    // Counter mode counts in-port bit 0 rising events; shift mode shifts in bit 0
    logic in0_prev_ff;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            in0_prev_ff <= 1'b0;
        else
            in0_prev_ff <= in_sync_ff[0];
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            shift_count_ff <= 4'h0;
        else if (wr_go && hit(req.adr, nad_pkg::OFS_SHIFT_COUNT) && req.sel[0])
            shift_count_ff <= req.dat[3:0];
        else if (shift_mode_ff)
            shift_count_ff <= {shift_count_ff[2:0], in_sync_ff[0]};
        else if (in_sync_ff[0] && !in0_prev_ff)
            shift_count_ff <= shift_count_ff + 4'h1;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            parallel_ff <= 8'h00;
            general_ff <= 4'h0;
            data_ff <= 4'h0;
        end
        else if (wr_go)
        begin
            if (hit(req.adr, nad_pkg::OFS_PARALLEL_OUT) && req.sel[0])
                parallel_ff <= req.dat[7:0];
            if (hit(req.adr, nad_pkg::OFS_GENERAL_OUT) && req.sel[0])
                general_ff <= req.dat[3:0];
            if (hit(req.adr, nad_pkg::OFS_DATA_OUT) && req.sel[0])
                data_ff <= req.dat[3:0];
        end
    end

    // Pins pass two flops before use
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_meta_ff <= 4'h0;
            in_sync_ff <= 4'h0;
        end
        else
        begin
            in_meta_ff <= in_port;
            in_sync_ff <= in_meta_ff;
        end
    end

    // Latches set while a line is high; reading status does not clear, a write of ones does
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            latch_ff <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (in_sync_ff[i*3])
                    latch_ff[i] <= 1'b1;
                else if (wr_go && hit(req.adr, nad_pkg::OFS_STATUS) && req.sel[0]
                         && req.dat[nad_pkg::STAT_LATCH_LSB + i])
                    latch_ff[i] <= 1'b0;
            end
        end
    end

    always_comb
    begin
        nxt_rdata = nad_pkg::RD_UNMAPPED;
        case (req.adr)
            nad_pkg::OFS_CONTROL:
                nxt_rdata[nad_pkg::CTRL_SHIFT_MODE_BIT] = shift_mode_ff;
            nad_pkg::OFS_STATUS:
            begin
                nxt_rdata[nad_pkg::STAT_ACC_LSB +: 4] = acc_ff;
                nxt_rdata[nad_pkg::STAT_CARRY_BIT] = carry_ff;
                nxt_rdata[nad_pkg::STAT_SKIP_BIT] = skip_ff;
                nxt_rdata[nad_pkg::STAT_LATCH_LSB +: 2] = latch_ff;
            end
            nad_pkg::OFS_POINTER: nxt_rdata[5:0] = ptr_ff;
            nad_pkg::OFS_PC: nxt_rdata[9:0] = pc_ff;
            nad_pkg::OFS_STACK_TOP: nxt_rdata[9:0] = stack_top_ff;
            nad_pkg::OFS_STACK_MID: nxt_rdata[9:0] = stack_mid_ff;
            nad_pkg::OFS_STACK_BOT: nxt_rdata[9:0] = stack_bot_ff;
            nad_pkg::OFS_SHIFT_COUNT: nxt_rdata[3:0] = shift_count_ff;
            nad_pkg::OFS_PARALLEL_OUT: nxt_rdata[7:0] = parallel_ff;
            nad_pkg::OFS_GENERAL_OUT: nxt_rdata[3:0] = general_ff;
            nad_pkg::OFS_DATA_OUT: nxt_rdata[3:0] = data_ff;
            default:
                nxt_rdata = nad_pkg::RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= nad_pkg::RD_UNMAPPED;
        end
        else
        begin
            ack_ff <= bus_go;
            if (bus_go && !req.we)
                rdata_ff <= nxt_rdata;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign parallel_out = parallel_ff;
    assign general_out = general_ff;
    assign data_out = data_ff;
    assign pc_out = pc_ff;

endmodule : nad_top
